// ---- logic/sfra_regs.vh ----
`ifndef SFRA_REGS_VH
`define SFRA_REGS_VH
// instruction codes
`define SFRA_OP_RD_SR1 8'h05
`define SFRA_OP_RD_SR2 8'h07
`define SFRA_OP_RD_CR 8'h35
`define SFRA_OP_BANK_RD 8'h16
`define SFRA_OP_BANK_WR 8'h17
`define SFRA_OP_BANK_OPEN 8'hB9
`define SFRA_OP_WR_REGS 8'h01
`define SFRA_OP_WRITE_ENABLE_CMD 8'h06
`define SFRA_OP_WRDI 8'h04
`define SFRA_OP_CLSR 8'h30
// status register one fields
`define SFRA_SR1_WIP 0
`define SFRA_SR1_WEL 1
`define SFRA_SR1_BP_LO 2
`define SFRA_SR1_BP_HI 4
`define SFRA_SR1_E_ERR 5
`define SFRA_SR1_P_ERR 6
`define SFRA_SR1_STATUS_WRITE_DISABLE 7
// configuration register quad bit
`define SFRA_CR_QUAD 1
// bank register extended addressing bit
`define SFRA_BANK_EXT 7
// reset values
`define SFRA_SR1_RST 8'h00
`define SFRA_SR2_RST 8'h00
`define SFRA_CR_RST 8'h00
`define SFRA_BANK_RST 8'h00
// self-timed register update, in ns, and in clk_sys cycles at 10 ns
`define SFRA_WR_TIME_NS 2000
`define SFRA_CLK_NS 10
`define SFRA_WR_CYC (`SFRA_WR_TIME_NS / `SFRA_CLK_NS)
`endif

// ---- logic/sfra_core.v ----
`timescale 1ns/1ns
`include "sfra_regs.vh"
// Operation
// [R1] opcode 05h shifts status register one out on so, any time
// [R2] opcode 07h shifts status register two out on so, any time
// [R3] opcode 35h shifts configuration register out, repeating every byte
// [R4] status value resampled at every eight-clock byte boundary
// [R5] opcode 16h shifts the eight-bit bank register out, repeating
// [R6] opcode 17h plus one byte loads bank register, no write enable
// [R7] bank bit 7 low: three-byte addresses take upper bits from bank
// [R8] bank write leaves program error, erase error and busy untouched
// [R9] host writes zero into reserved bank register bits
// [R10] after B9h, register write loads bank bits 1:0 only
// [R11] that write closes bank access, extended bit unchanged
// [R12] any other command or frame after B9h closes bank access
// [R13] host issues B9h pair only when idle or suspended, no errors
// [R14] register write 01h accepted only with write enable latch set
// [R15] 8 bits writes status, 16 writes both, else cancelled
// [R16] host uses sixteen-bit register write when quad bit set
// [R17] frame end starts timed update; busy set, then busy and latch clear; after a failed update status bit 0 stays set
// [R18] failed update sets program or erase error flag
// [R19] host writes zero into reserved status and configuration bits
// [R20] status-write-disable low: writes allowed with latch set
// [R21] disable high and protect pin low: writes rejected
// [R22] disable high and protect pin high: writes allowed with latch
// [R23] opcode 06h sets write enable latch, status bit 1
// [R24] quad mode turns hardware write protection off
// [R25] status one: busy bit 0, latch bit 1, protect 4:2, disable 7
module sfra_core #(
  parameter WR_CYCLES = `SFRA_WR_CYC
) (
  input wire clk_sys,
  input wire rst_n,
  input wire cs_n,
  input wire sck,
  input wire si,
  input wire wp_n,
  input wire upd_fail,
  input wire [23:0] addr_3b,
  output reg so,
  output reg so_oe,
  output reg [31:0] addr_ext,
  output reg [7:0] bank_address_ext,
  output reg [7:0] status_one,
  output reg [7:0] config_reg,
  output reg write_in_progress
);
  localparam ST_OP = 2'd0;
  localparam ST_OUT = 2'd1;
  localparam ST_DATA = 2'd2;
  localparam ST_SKIP = 2'd3;

  // pin synchronisers, one two-flop chain per pin
  // pin order: 3 cs_n, 2 sck, 1 si, 0 wp_n
  localparam [3:0] PIN_IDLE = 4'b1000;
  wire [3:0] pin_raw = {cs_n, sck, si, wp_n};
  wire [3:0] pin_sync;
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_sync
      reg [1:0] sync_q;
      // only the second flop is read outside the chain
      always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)
          sync_q <= {2{PIN_IDLE[gi]}};
        else
          sync_q <= {sync_q[0], pin_raw[gi]};
      end
      assign pin_sync[gi] = sync_q[1];
    end
  endgenerate
  wire cs_sync = pin_sync[3];
  wire sck_sync = pin_sync[2];
  wire si_sync = pin_sync[1];
  wire wp_sync = pin_sync[0];

  // sck edge detector, idles low like the pin
  reg sck_d1_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      sck_d1_q <= 1'b0;
    else
      sck_d1_q <= sck_sync;
  end
  wire sck_rise = sck_sync & ~sck_d1_q;
  wire sck_fall = ~sck_sync & sck_d1_q;

  // chip select level and its rising edge, the frame end
  wire cs_act = ~cs_sync;
  reg cs_act_q;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      cs_act_q <= 1'b0;
    else
      cs_act_q <= cs_act;
  end
  wire frame_end = cs_act_q & ~cs_act;

  reg [1:0] st_q;
  reg [7:0] op_q;
  reg [7:0] sh_in_q;
  reg [2:0] bit_q;
  reg [4:0] dcnt_q;
  reg [7:0] d0_q, d1_q;
  // output byte and register-side state
  reg [7:0] out_q;
  reg [7:0] sr2_q;
  reg bank_open_q;
  // captured write data and update timer
  reg [15:0] wr_val_q;
  reg wr_both_q;
  reg [31:0] tmr_q;

  // opcode or data byte as it completes
  wire [7:0] op_now = {sh_in_q[6:0], si_sync};
  wire quad = config_reg[`SFRA_CR_QUAD];
  wire status_write_disable = status_one[`SFRA_SR1_STATUS_WRITE_DISABLE];
  wire write_enable_latch = status_one[`SFRA_SR1_WEL];
  // hardware protection, ignored in quad mode
  wire hw_prot = status_write_disable & ~wp_sync & ~quad; // [R21] [R24]
  wire wr_ok = write_enable_latch & ~hw_prot; // [R14] [R20] [R22]

  // byte to shift out for a read opcode, sampled at each byte start
  reg [7:0] rd_val;
  always @* begin
    case (op_q)
      `SFRA_OP_RD_SR1: rd_val = status_one; // [R1] [R4]
      `SFRA_OP_RD_SR2: rd_val = sr2_q; // [R2] [R4]
      `SFRA_OP_RD_CR: rd_val = config_reg; // [R3]
      `SFRA_OP_BANK_RD: rd_val = bank_address_ext; // [R5]
      default: rd_val = 8'h00;
    endcase
  end
  wire is_rd = (op_now == `SFRA_OP_RD_SR1) | (op_now == `SFRA_OP_RD_SR2) |
    (op_now == `SFRA_OP_RD_CR) | (op_now == `SFRA_OP_BANK_RD);

  // bit counter cleared between frames, input shift register keeps its value
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sh_in_q <= 8'h00;
      bit_q <= 3'd0;
    end else if (!cs_act) begin
      bit_q <= 3'd0;
    end else if (sck_rise) begin
      sh_in_q <= op_now;
      bit_q <= bit_q + 3'd1;
    end
  end

  // opcode decode at the eighth bit of a frame
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_OP;
      op_q <= 8'h00;
    end else if (!cs_act) begin
      st_q <= ST_OP;
    end else if (sck_rise) begin
      case (st_q)
        ST_OP: begin
          if (bit_q == 3'd7) begin
            op_q <= op_now;
            if (is_rd) begin
              st_q <= ST_OUT;
            end else if (op_now == `SFRA_OP_WR_REGS ||
                         op_now == `SFRA_OP_BANK_WR) begin
              st_q <= ST_DATA;
            end else begin
              st_q <= ST_SKIP;
            end
          end
        end
        default: begin
          st_q <= st_q;
        end
      endcase
    end
  end

  // data bit count and the two captured data bytes
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      dcnt_q <= 5'd0;
      d0_q <= 8'h00;
      d1_q <= 8'h00;
    end else if (!cs_act) begin
      dcnt_q <= 5'd0;
    end else if (sck_rise && st_q == ST_DATA) begin
      // count saturates so long frames stay rejected
      if (dcnt_q != 5'd31)
        dcnt_q <= dcnt_q + 5'd1;
      if (bit_q == 3'd7 && dcnt_q == 5'd7)
        d0_q <= op_now;
      if (bit_q == 3'd7 && dcnt_q == 5'd15)
        d1_q <= op_now;
    end
  end

  // output shifter, a fresh byte taken at each eight-clock boundary
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      out_q <= 8'h00;
      so <= 1'b0;
      so_oe <= 1'b0;
    end else if (!cs_act) begin
      so_oe <= 1'b0;
    end else if (sck_fall && st_q == ST_OUT) begin
      so_oe <= 1'b1;
      if (bit_q == 3'd0) begin
        so <= rd_val[7]; // [R4]
        out_q <= {rd_val[6:0], 1'b0};
      end else begin
        so <= out_q[7];
        out_q <= {out_q[6:0], 1'b0};
      end
    end
  end

  // completed frame classification, from state left at cs_n rise
  wire [7:0] eop = op_q;
  wire whole_op = (st_q != ST_OP);
  wire wr8 = (dcnt_q == 5'd8);
  wire wr16 = (dcnt_q == 5'd16);
  wire busy = write_in_progress;
  wire wr_bytes = (dcnt_q >= 5'd8);
  wire end_skip = frame_end & whole_op & (st_q == ST_SKIP);
  wire end_data = frame_end & (st_q == ST_DATA);

  // one-byte commands, acted on at frame end
  wire do_open = end_skip & (eop == `SFRA_OP_BANK_OPEN) & ~bank_open_q;
  wire do_write_enable_cmd = end_skip & (eop == `SFRA_OP_WRITE_ENABLE_CMD) & ~busy; // [R23]
  wire do_wrdi = end_skip & (eop == `SFRA_OP_WRDI) & ~busy;
  wire do_clsr = end_skip & (eop == `SFRA_OP_CLSR);

  // bank write needs a whole data byte, no latch
  wire do_bank_wr = end_data & (eop == `SFRA_OP_BANK_WR) &
    wr_bytes; // [R6]

  // register write: bank bits while the window is open, else registers
  wire wrr_end = end_data & (eop == `SFRA_OP_WR_REGS);
  wire do_bank_lo = wrr_end & bank_open_q & wr_bytes; // [R10]
  wire do_wrr = wrr_end & ~bank_open_q & ~busy & wr_ok &
    (wr8 | wr16); // [R14] [R15]

  // timed update ends on its last count, held off by a frame end
  wire upd_done = write_in_progress & ~frame_end & (tmr_q <= 32'd1);

  // self-timed update counter
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tmr_q <= 32'd0;
    end else if (do_wrr) begin
      tmr_q <= WR_CYCLES;
    end else if (write_in_progress && !frame_end && tmr_q > 32'd1) begin
      tmr_q <= tmr_q - 32'd1;
    end
  end

  // busy level and the captured write data
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_in_progress <= 1'b0;
      wr_val_q <= 16'h0000;
      wr_both_q <= 1'b0;
    end else if (do_wrr) begin
      wr_val_q <= {d0_q, d1_q};
      wr_both_q <= wr16; // [R15]
      write_in_progress <= 1'b1; // [R17]
    end else if (upd_done) begin
      write_in_progress <= 1'b0; // [R17]
    end
  end

  // bank register and its legacy access window
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      bank_address_ext <= `SFRA_BANK_RST;
      bank_open_q <= 1'b0;
    end else begin
      // any frame after the opener closes the window
      if (frame_end)
        bank_open_q <= do_open; // [R11] [R12]
      // flags live elsewhere, so a bank write cannot touch them
      if (do_bank_wr)
        bank_address_ext <= d0_q; // [R6] [R8]
      else if (do_bank_lo)
        bank_address_ext[1:0] <= d0_q[1:0]; // [R10] [R11]
    end
  end

  // configuration register, written only by the sixteen-bit form
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      config_reg <= `SFRA_CR_RST;
    else if (upd_done && !upd_fail && wr_both_q)
      config_reg <= wr_val_q[7:0]; // [R15]
  end

  // status register two has no writer here
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      sr2_q <= `SFRA_SR2_RST;
    else
      sr2_q <= sr2_q;
  end

  // status register one: hardware bits and the written fields
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      status_one <= `SFRA_SR1_RST;
    end else if (do_wrr) begin
      status_one[`SFRA_SR1_WIP] <= 1'b1; // [R17]
    end else if (upd_done && upd_fail) begin
      // busy bit stays up while an error is reported
      status_one[`SFRA_SR1_P_ERR] <= 1'b1; // [R18]
      status_one[`SFRA_SR1_E_ERR] <= 1'b1;
      status_one[`SFRA_SR1_WEL] <= 1'b0; // [R17]
    end else if (upd_done) begin
      // [R25] written disable and protect, hardware error bits kept
      status_one <= {wr_val_q[15], status_one[6:5],
        wr_val_q[12:10], 2'b00}; // [R17]
    end else begin
      if (do_write_enable_cmd)
        status_one[`SFRA_SR1_WEL] <= 1'b1; // [R23]
      if (do_wrdi)
        status_one[`SFRA_SR1_WEL] <= 1'b0;
      // clearing errors also drops a busy bit left by a failure
      if (do_clsr) begin
        status_one[`SFRA_SR1_E_ERR] <= 1'b0;
        status_one[`SFRA_SR1_P_ERR] <= 1'b0;
        if (!busy)
          status_one[`SFRA_SR1_WIP] <= 1'b0;
      end
    end
  end

  // address extension for three-byte commands
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n)
      addr_ext <= 32'h00000000;
    else if (!bank_address_ext[`SFRA_BANK_EXT])
      addr_ext <= {1'b0, bank_address_ext[6:0], addr_3b}; // [R7]
    else
      addr_ext <= {8'h00, addr_3b};
  end
endmodule // sfra_core

// ---- bench/sfra_props.sv ----
`timescale 1ns/1ns
// port checker for the register access core
module sfra_props (
  input logic clk_sys,
  input logic rst_n,
  input logic cs_n,
  input logic so_oe,
  input logic [23:0] addr_3b,
  input logic [31:0] addr_ext,
  input logic [7:0] bank_address_ext,
  input logic [7:0] status_one,
  input logic write_in_progress
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // start of a timed register update
  sequence s_wr_start;
    $rose(write_in_progress);
  endsequence
  // address extension, busy window and frame-end effects
  a_ext_bank_low: assert property ($past(rst_n) && !bank_address_ext[7]
    |=> addr_ext == {1'b0, $past(bank_address_ext[6:0]), $past(addr_3b)})
    else $error("bank extension wrong");
  a_ext_bank_high: assert property ($past(rst_n) && bank_address_ext[7]
    |=> addr_ext == {8'h00, $past(addr_3b)})
    else $error("extended address wrong");
  a_busy_at_end: assert property (s_wr_start |-> cs_n)
    else $error("update began inside a frame");
  a_busy_hold: assert property (s_wr_start |=> write_in_progress[*8])
    else $error("busy dropped early");
  a_busy_latch: assert property (s_wr_start |-> status_one[1])
    else $error("write taken without latch");
  a_busy_status: assert property (s_wr_start |-> ##[0:1] status_one[0])
    else $error("status busy bit missing");
  a_latch_clear: assert property ($fell(write_in_progress)
    |-> ##[0:2] !status_one[1]) else $error("latch kept");
  a_bank_frame: assert property (!$stable(bank_address_ext) |-> cs_n)
    else $error("bank changed inside frame");
  a_prot_frame: assert property (!$stable({status_one[7], status_one[4:2]})
    |-> $fell(write_in_progress)) else $error("status changed early");
  a_oe_release: assert property ($rose(cs_n) |-> ##6 !so_oe)
    else $error("output kept after frame");
endmodule // sfra_props
bind sfra_core sfra_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .cs_n(cs_n), .so_oe(so_oe), .addr_3b(addr_3b), .addr_ext(addr_ext),
  .bank_address_ext(bank_address_ext), .status_one(status_one),
  .write_in_progress(write_in_progress));

// ---- bench/sfra_host.sv ----
`timescale 1ns/1ns
// host controller: mode 0 frames, sck idles low
module sfra_host (
  input wire clk_sys,
  input wire so,
  output logic cs_n = 1'b1,
  output logic sck = 1'b0,
  output logic si = 1'b0
);
  // n bits of tx msb first, so captured at each sck rise
  task automatic frame(input logic [31:0] tx, input int n,
                       output logic [31:0] rx);
    rx = '0;
    @(posedge clk_sys) cs_n <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      si <= tx[i];
      repeat (8) @(posedge clk_sys);
      sck <= 1'b1;
      rx = {rx[30:0], so};
      repeat (8) @(posedge clk_sys);
      sck <= 1'b0;
    end
    repeat (8) @(posedge clk_sys);
    cs_n <= 1'b1;
    si <= ~si; // idle line carries no stale bit
    repeat (8) @(posedge clk_sys);
  endtask
endmodule // sfra_host

// ---- bench/tb_spi_flash_register_access.sv ----
`timescale 1ns/1ns
module tb_spi_flash_register_access;
  logic clk_sys = 0, rst_n = 0, wp_n = 0, upd_fail = 0;
  logic [23:0] addr_3b = 0;
  logic [31:0] rx, v;
  logic [7:0] sr1 = 0, cr = 0, bank = 0;
  wire cs_n, sck, si, so, so_oe, write_in_progress;
  wire [31:0] addr_ext;
  wire [7:0] bank_address_ext, status_one, config_reg;
  integer n_mismatch = 0, checked = 0, seed = 12508;
  always #5 clk_sys = ~clk_sys;
  sfra_core #(.WR_CYCLES(600)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .cs_n(cs_n), .sck(sck), .si(si), .wp_n(wp_n), .upd_fail(upd_fail),
    .addr_3b(addr_3b), .so(so), .so_oe(so_oe), .addr_ext(addr_ext),
    .bank_address_ext(bank_address_ext), .status_one(status_one),
    .config_reg(config_reg), .write_in_progress(write_in_progress));
  sfra_host host (.clk_sys(clk_sys), .so(so_oe ? so : ~so), .cs_n(cs_n),
    .sck(sck),
    .si(si));
  // compare and verdict
  task chk(input logic [31:0] act, input logic [31:0] exp);
    checked++;
    if (act !== exp) begin
      n_mismatch++;
      $display("MISMATCH %0t act=%h exp=%h", $time, act, exp);
    end
  endtask
  task finish_test;
    if (n_mismatch == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // frames, reads and register writes
  task fr(input logic [31:0] tx, input int n);
    host.frame(tx, n, rx);
    for (int i = 0; i < 800 && write_in_progress !== 1'b0; i++)
      @(posedge clk_sys);
  endtask
  task rd(input logic [7:0] op, input logic [7:0] e);
    host.frame({op, 16'h0000}, 24, rx);
    chk(rx[15:0], {e, e});
  endtask
  task wr(input logic [15:0] d, input int n, input logic ok);
    fr(8'h06, 8);
    chk(status_one, sr1 | 8'h02);
    host.frame({8'h01, d} >> (16 - n), 8 + n, rx);
    if (ok) begin
      chk(write_in_progress, 1'b1);
      host.frame({8'h05, 16'h0000}, 24, rx);
      chk({rx[8], rx[0]}, 2'b11);
      if (!upd_fail) begin
        sr1 = (d[15:8] & 8'h9C) | (sr1 & 8'h60);
        if (n == 16) cr = d[7:0];
      end
    end
    fr(8'h04, 8);
    if (upd_fail)
      chk(status_one[6:5], 2'b11);
    else
      chk({status_one, config_reg}, {sr1, cr});
  endtask
  // main sequence
  initial begin
    repeat (3) @(posedge clk_sys);
    rst_n <= 1;
    repeat (4) @(posedge clk_sys);
    chk({status_one, config_reg, bank_address_ext}, 0);
    rd(8'h05, 0);
    rd(8'h07, 0);
    rd(8'h35, 0);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      bank = {v[30], 5'h00, v[1:0]};
      addr_3b <= v[23:0];
      fr({8'h17, bank}, 16);
      chk(bank_address_ext, bank);
      rd(8'h16, bank);
      chk(addr_ext, bank[7] ? {8'h00, v[23:0]} : {1'b0, bank[6:0],
        v[23:0]});
      chk(status_one, sr1);
    end
    fr({8'h01, 8'h9C}, 16);
    chk(status_one, sr1);
    wr({{1'b0, v[14:8]} | 8'h1C, 8'h00}, 8, 1);
    wr(16'h8802, 12, 0);
    wr(16'h8800, 16, 1);
    wr(16'h0400, 16, 0);
    wp_n <= 1;
    wr(16'h8C02, 16, 1);
    wp_n <= 0;
    wr(16'h9002, 16, 1);
    fr(8'hB9, 8);
    fr({8'h01, 8'hFE, 8'h55}, 24);
    bank[1:0] = 2'b10;
    chk({bank_address_ext, status_one}, {bank, sr1});
    fr(8'hB9, 8);
    rd(8'h05, sr1);
    fr({8'h01, 8'h01, 8'h00}, 24);
    chk({bank_address_ext, status_one}, {bank, sr1});
    upd_fail <= 1;
    wr(16'h8002, 16, 1);
    fr(8'h30, 8);
    chk(status_one, sr1);
    finish_test;
  end
  // watchdog
  initial begin
    #600000;
    n_mismatch++;
    finish_test;
  end
endmodule // tb_spi_flash_register_access
